// *** rtl/dac_sync_gate_and_dll_control.sv ***
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps
// Overview of operation
// - Gate low: zeros replace captured sample words at sample_o, not at the output shares
// - Rising gate edge fires configured sync event
// - Sync bit sampled alongside each data word
// - Software sync bits substitute for pin
// - Loop skews data clock against data
// - Restart bit begins fresh lock attempt
// - Lock status bit readable in status
// - Four-bit coarse gain field held
// - Offset binary code mapped to output shares
// - Sample on both data clock edges
module dac_sync_gate_and_dll_control
    import dac_ctrl_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Link pins
    input  wire logic         source_data_clock_i,
    input  wire logic [W-1:0] data_i,
    input  wire logic         sync_txen_pair_i,
    // Processing path
    output logic [W-1:0]      sample_o,
    output logic              sample_valid_o,
    output logic              sync_event_o,
    output logic [7:0]        sync_effects_o,
    output logic [W-1:0]      true_share_o,
    output logic [W-1:0]      comp_share_o,
    output logic [3:0]        coarse_output_gain_o,
    output logic [2:0]        dll_ifixed_o,
    output logic [3:0]        dll_delay_o,
    output logic              irq_o
);
    import dac_ctrl_pkg::*;

    // Pin synchronisers
    logic [W-1:0] data_m_r, data_s_r;      // Data two stages
    logic         sync_m_r, sync_s_r;      // Sync two stages
    logic         clk_m_r, clk_s_r;        // Link clock two stages
    logic         clk_d_r;                 // Previous synced link clock

    // Registers
    logic [7:0]   cfg_one_r;               // Sync effects, first group
    logic [7:0]   cfg_five_r;              // Sync effects, second group
    logic         sw_sel_r;                // Software sync select
    logic         sw_sync_r;               // Software sync level
    logic [3:0]   gain_r;                  // Coarse gain
    logic [2:0]   ifix_r;                  // Loop fixed current
    logic [3:0]   delay_r;                 // Loop delay
    logic [2:0]   irq_stat_r;              // Sticky events
    logic [2:0]   irq_mask_r;              // Event mask
    logic         gate_d_r;                // Previous gate level
    dll_state_t   dll_r;                   // Loop state
    logic [4:0]   good_cnt_r;              // Consecutive good edges
    logic [5:0]   stall_cnt_r;             // Cycles since last edge
    logic [W-1:0] stored_word;             // Word from capture stage
    logic         stored_sync;             // Sync bit from capture stage

    // Bus decode
    wire        wr_en    = psel && penable && pwrite;
    wire        rd_en    = psel && !pwrite;
    wire [7:0]  addr     = paddr[7:0];
    wire        hit_one  = (addr == ADDR_CFG_ONE);
    wire        hit_thr  = (addr == ADDR_CFG_THREE);
    wire        hit_five = (addr == ADDR_CFG_FIVE);
    wire        hit_sev  = (addr == ADDR_CFG_SEVEN);
    wire        hit_eig  = (addr == ADDR_CFG_EIGHT);
    wire        hit_ten  = (addr == ADDR_CFG_TEN);
    wire        hit_st0  = (addr == ADDR_STAT_ZERO);
    wire        hit_ist  = (addr == ADDR_IRQ_STAT);
    wire        hit_imk  = (addr == ADDR_IRQ_MASK);
    wire        mapped   = hit_one | hit_thr | hit_five | hit_sev | hit_eig
                         | hit_ten | hit_st0 | hit_ist | hit_imk;
    wire        restart  = wr_en && hit_eig && pwdata[RESTART_BIT];

    // Link clock edges found by the reference clock
    wire        clk_rise = clk_s_r && !clk_d_r;
    wire        clk_fall = !clk_s_r && clk_d_r;
    wire        clk_edge = clk_rise | clk_fall;
    wire        locked   = (dll_r == DLL_LOCK);

    // Effective gate: software level replaces pin when selected
    wire        gate     = sw_sel_r ? sw_sync_r : stored_sync;
    wire        gate_up  = gate && !gate_d_r;
    wire        lock_ev  = (dll_r == DLL_ACQ) && clk_edge
                         && (good_cnt_r == 5'(LOCK_EDGES - 1));
    wire        loss_ev  = locked && (stall_cnt_r == 6'(STALL_CYC));
    wire [2:0]  ev       = {loss_ev, lock_ev, gate_up};

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq_o   = |(irq_stat_r & ~irq_mask_r);                             // Set mask bit blocks its event

    // Two-stage synchronisers on every pin
    always_ff @(posedge ref_clk_i) begin
        data_m_r <= data_i;
        data_s_r <= data_m_r;
        sync_m_r <= sync_txen_pair_i;
        sync_s_r <= sync_m_r;
        clk_m_r  <= source_data_clock_i;
        clk_s_r  <= clk_m_r;
        clk_d_r  <= clk_s_r;
    end

    // Capture word and sync together on each clock edge while the loop is locked
    sample_pipe #(.W(W)) u_pipe (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .load_i    (clk_edge && locked),
        .word_i    (data_s_r),
        .sync_i    (sync_s_r),
        .word_o    (stored_word),
        .sync_o    (stored_sync),
        .true_o    (true_share_o),
        .comp_o    (comp_share_o)
    );

    // Configuration registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_one_r  <= CFG_ONE_RST;
            cfg_five_r <= CFG_FIVE_RST;
            sw_sel_r   <= 1'b0;
            sw_sync_r  <= 1'b0;
            gain_r     <= GAIN_RST;
            ifix_r     <= IFIX_RST;
            delay_r    <= DELAY_RST;
            irq_mask_r <= MASK_RST;
        end else if (wr_en) begin
            if (hit_one) begin
                cfg_one_r <= pwdata[7:0];
            end else if (hit_five) begin
                cfg_five_r <= pwdata[7:0];
            end else if (hit_thr) begin
                sw_sel_r  <= pwdata[SW_SEL_BIT];
                sw_sync_r <= pwdata[SW_SYNC_BIT];
            end else if (hit_sev) begin
                gain_r <= pwdata[3:0];
            end else if (hit_ten) begin
                ifix_r  <= pwdata[IFIX_LSB +: 3];
                delay_r <= pwdata[DELAY_LSB +: 4];
            end else if (hit_imk) begin
                irq_mask_r <= pwdata[2:0];
            end
        end
    end

    // Sticky events, set wins over write-one clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((wr_en && hit_ist) ? pwdata[2:0] : 3'h0)) | ev;
        end
    end

    // Loop: acquire by counting steady clock edges, drop on stall
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dll_r       <= DLL_IDLE;
            good_cnt_r  <= '0;
            stall_cnt_r <= '0;
        end else begin
            if (clk_edge || restart) begin
                stall_cnt_r <= '0;
            end else if (stall_cnt_r != 6'(STALL_CYC)) begin
                stall_cnt_r <= stall_cnt_r + 6'h1;
            end
            if (restart) begin
                dll_r      <= DLL_ACQ;
                good_cnt_r <= '0;
            end else begin
                case (dll_r)
                    DLL_IDLE: begin
                        good_cnt_r <= '0;
                    end
                    DLL_ACQ: begin
                        if (stall_cnt_r == 6'(STALL_CYC)) begin
                            good_cnt_r <= '0;
                        end else if (clk_edge) begin
                            if (lock_ev) begin
                                dll_r <= DLL_LOCK;
                            end
                            good_cnt_r <= good_cnt_r + 5'h1;
                        end
                    end
                    DLL_LOCK: begin
                        if (loss_ev) begin
                            dll_r <= DLL_ACQ;
                            good_cnt_r <= '0;
                        end
                    end
                    default: begin
                        dll_r <= DLL_IDLE;
                    end
                endcase
            end
        end
    end

    // Gate level history and output sample
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gate_d_r       <= 1'b0;
            sample_o       <= '0;
            sample_valid_o <= 1'b0;
            sync_event_o   <= 1'b0;
        end else begin
            gate_d_r       <= gate;
            sample_o       <= gate ? stored_word : '0;
            sample_valid_o <= gate;
            sync_event_o   <= gate_up;
        end
    end

    assign sync_effects_o       = cfg_one_r | cfg_five_r;
    assign coarse_output_gain_o = gain_r;
    assign dll_ifixed_o         = ifix_r;
    assign dll_delay_o          = delay_r;

    // Read data
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prdata <= '0;
        end else if (rd_en && !penable) begin
            if (hit_one) prdata <= {24'h0, cfg_one_r};
            else if (hit_five) prdata <= {24'h0, cfg_five_r};
            else if (hit_thr) prdata <= {30'h0, sw_sync_r, sw_sel_r};
            else if (hit_sev) prdata <= {28'h0, gain_r};
            else if (hit_ten) prdata <= {24'h0, delay_r, 1'b0, ifix_r};
            else if (hit_st0) prdata <= {30'h0, gate, locked};
            else if (hit_ist) prdata <= {29'h0, irq_stat_r};
            else if (hit_imk) prdata <= {29'h0, irq_mask_r};
            else prdata <= '0;
        end
    end

    // Zero fed when gate is low
    a_gate_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !$past(gate) |-> sample_o == '0) else $error("sample not zero");
    // Sync pulse follows a rising gate
    a_sync_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        gate && !gate_d_r |=> sync_event_o) else $error("no sync event");
    // Software select routes software level
    a_sw_route: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sw_sel_r |-> gate == sw_sync_r) else $error("sw sync ignored");
    // Restart leaves lock
    a_restart_acq: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        restart |=> dll_r == DLL_ACQ) else $error("restart ignored");
    // Lock only after enough edges
    a_lock_count: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(locked) |-> $past(good_cnt_r) == 5'(LOCK_EDGES - 1)) else $error("early lock");
    // Unmasked sticky sync event raises the interrupt
    a_irq_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        irq_stat_r[EV_SYNC] && !irq_mask_r[EV_SYNC] |-> irq_o) else $error("irq mismatch");
    // Status read returns the lock state seen at setup
    a_lock_status: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_en && !penable && hit_st0 |=> prdata[LOCK_BIT] == $past(locked)) else $error("lock bit wrong");
    // Shares sum to full scale
    a_share_sum: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (true_share_o ^ comp_share_o) == '1) else $error("share mismatch");
    // Capture only on link edges
    a_capture_edge: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        stored_word != $past(stored_word) |-> $past(clk_edge)) else $error("stray capture");
endmodule : dac_sync_gate_and_dll_control

// *** rtl/dac_ctrl_pkg.sv ***
package dac_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CFG_ONE   = 8'h00;   // Sync effect enables, part one
    localparam logic [7:0] ADDR_CFG_THREE = 8'h04;   // Software sync controls
    localparam logic [7:0] ADDR_CFG_FIVE  = 8'h08;   // Sync effect enables, part two
    localparam logic [7:0] ADDR_CFG_SEVEN = 8'h0c;   // Coarse gain
    localparam logic [7:0] ADDR_CFG_EIGHT = 8'h10;   // Loop restart
    localparam logic [7:0] ADDR_CFG_TEN   = 8'h14;   // Loop current and delay
    localparam logic [7:0] ADDR_STAT_ZERO = 8'h18;   // Lock and gate state
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h1c;   // Sticky events
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h20;   // Event mask
    // Field positions
    localparam int SW_SEL_BIT   = 0;                  // Software sync select
    localparam int SW_SYNC_BIT  = 1;                  // Software sync level
    localparam int RESTART_BIT  = 0;                  // Loop restart strobe
    localparam int IFIX_LSB     = 0;                  // Fixed current field
    localparam int DELAY_LSB    = 4;                  // Delay field
    localparam int LOCK_BIT     = 0;                  // Lock status
    localparam int GATE_BIT     = 1;                  // Transmit gate status
    localparam int EV_SYNC      = 0;                  // Sync event
    localparam int EV_LOCK      = 1;                  // Lock achieved
    localparam int EV_LOSS      = 2;                  // Lock lost
    // Reset values
    localparam logic [7:0] CFG_ONE_RST   = 8'h00;
    localparam logic [7:0] CFG_FIVE_RST  = 8'h00;
    localparam logic [3:0] GAIN_RST      = 4'hf;
    localparam logic [2:0] IFIX_RST      = 3'h0;
    localparam logic [3:0] DELAY_RST     = 4'h0;
    localparam logic [2:0] MASK_RST      = 3'h0;
    // Timing: lock needs this many consecutive good clock edges
    localparam int LOCK_EDGES    = 16;
    // Link clock stall timeout
    localparam int STALL_NS      = 1000;
    localparam int CLK_NS        = 40;
    localparam int STALL_CYC     = STALL_NS / CLK_NS; // Longest time rounds down
    // Loop state machine
    typedef enum logic [1:0] {
        DLL_IDLE = 2'b00,
        DLL_ACQ  = 2'b01,
        DLL_LOCK = 2'b10
    } dll_state_t;
endpackage : dac_ctrl_pkg

// *** rtl/sample_pipe.sv ***
`timescale 1ns/100ps
// Holds captured sample with its sync bit and maps it to output shares
module sample_pipe #(
    parameter int W = 16
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,      // Capture strobe
    input  wire logic [W-1:0] word_i,      // Sampled word
    input  wire logic         sync_i,      // Sampled sync bit
    output logic [W-1:0]      word_o,      // Stored word
    output logic              sync_o,      // Stored sync bit
    output logic [W-1:0]      true_o,      // True output share
    output logic [W-1:0]      comp_o       // Complement output share
);
    // Word and sync stored together so they stay aligned
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            word_o <= '0;
            sync_o <= 1'b0;
        end else if (load_i) begin
            word_o <= word_i;
            sync_o <= sync_i;
        end
    end

    // Offset binary: complement share is code, true share is max minus code
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            true_o <= '1;
            comp_o <= '0;
        end else begin
            comp_o <= word_o;
            true_o <= ~word_o;
        end
    end
endmodule : sample_pipe

// *** dv/link_source.sv ***
`timescale 1ns/100ps
// Serializer-side model: DDR words against a half-rate link clock
module link_source #(
    parameter int W       = 16,
    parameter int HALF_NS = 160
) (
    input  wire logic         run_i,   // Clock runs while high
    input  wire logic         txen_i,  // Level for the sync pin
    input  wire logic [W-1:0] word_i,  // Word to send
    output logic              clk_o,   // Link clock
    output logic [W-1:0]      data_o,  // Data pins
    output logic              sync_o   // Sync pin
);
    // Data centred between edges, phase unrelated to the core clock
    initial begin
        clk_o  = 1'b0;
        data_o = '0;
        sync_o = 1'b0;
        #3;
        forever begin
            #(HALF_NS / 2);
            if (run_i) begin
                data_o = word_i;
                sync_o = txen_i;
            end else begin // Idle bus inverts every bit each half period, so the last word returns every other half period
                data_o = ~data_o;
            end
            #(HALF_NS / 2);
            if (run_i) begin
                clk_o = ~clk_o;
            end
        end
    end
endmodule : link_source

// *** dv/test_dac_sync_gate_and_dll_control.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t: got %h want %h", $time, (g), (e)); end end
// Register-level bench with a serializer model on the link pins
module test_dac_sync_gate_and_dll_control;
    import dac_ctrl_pkg::*;
    logic        ref_clk_i = 1'b0;        // Core clock
    logic        rst_i, psel, penable, pwrite, pready, pslverr, lclk, lsync;
    logic [31:0] paddr, pwdata, prdata, rq; // Bus and read result
    logic        re, run, txen, sv, se, irq; // Flags and model controls
    logic [15:0] word, ldata, sample, tsh, csh; // Words and shares
    logic [7:0]  eff;                     // Sync effect enables
    logic [3:0]  gain, dly;               // Gain and delay fields
    logic [2:0]  ifx;                     // Current field
    logic [15:0] codes [2] = '{16'h0000, 16'hffff}; // Code extremes
    int          n_mismatch, checks, i;  // Counters

    always #20 ref_clk_i = ~ref_clk_i;

    dac_sync_gate_and_dll_control i_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .source_data_clock_i(lclk),
        .data_i(ldata), .sync_txen_pair_i(lsync), .sample_o(sample),
        .sample_valid_o(sv), .sync_event_o(se), .sync_effects_o(eff),
        .true_share_o(tsh), .comp_share_o(csh), .coarse_output_gain_o(gain),
        .dll_ifixed_o(ifx), .dll_delay_o(dly), .irq_o(irq));

    link_source i_src (.run_i(run), .txen_i(txen), .word_i(word),
        .clk_o(lclk), .data_o(ldata), .sync_o(lsync));

    // Verdict and end of run
    task results;
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    // A wait that ran out
    task timeout;
        n_mismatch++;
        results();
    endtask : timeout

    task idle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : idle

    // One APB transfer; result left in rq and re
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge ref_clk_i);
            if (pready === 1'b1) break;
        end
        if (k == 16) timeout();
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rq, e)
    endtask : rdc

    // Hang guard
    initial begin
        #3000000;
        timeout();
    end

    // Main sequence
    initial begin
        rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; run = 1'b0; txen = 1'b0; word = 16'ha5c3;
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdc(ADDR_CFG_SEVEN, {28'h0, GAIN_RST});
        rdc(ADDR_STAT_ZERO, 32'h0);
        apb(1'b1, 8'h40, 32'hffff_ffff);
        `CHK(re, 1'b1)
        rdc(8'h40, 32'h0);
        `CHK(re, 1'b1)
        apb(1'b1, ADDR_CFG_SEVEN, 32'h6);
        apb(1'b1, ADDR_CFG_TEN, 32'h95);
        idle(1);
        `CHK(gain, 4'h6)
        `CHK(ifx, 3'h5)
        `CHK(dly, 4'h9)
        rdc(ADDR_CFG_TEN, 32'h95);
        apb(1'b1, ADDR_CFG_EIGHT, 32'h1);
        idle(40);
        rdc(ADDR_STAT_ZERO, 32'h0);
        run <= 1'b1;
        for (i = 0; i < 64; i++) begin
            apb(1'b0, ADDR_STAT_ZERO, 32'h0);
            if (rq[LOCK_BIT] === 1'b1) break;
        end
        if (i == 64) timeout();
        rdc(ADDR_IRQ_STAT, 32'h2);
        `CHK(irq, 1'b1)
        apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        idle(20);
        `CHK(irq, 1'b0)
        `CHK(sv, 1'b0)
        `CHK(sample, 16'h0)
        apb(1'b1, ADDR_CFG_ONE, 32'h3c);
        apb(1'b1, ADDR_CFG_FIVE, 32'h41);
        idle(1);
        `CHK(eff, 8'h7d)
        txen <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk_i);
            if (se === 1'b1) break;
        end
        if (i == 64) timeout();
        idle(1);
        `CHK(se, 1'b0)
        idle(20);
        `CHK(sv, 1'b1)
        `CHK(sample, word)
        `CHK(irq, 1'b1)
        rdc(ADDR_IRQ_STAT, 32'h1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        idle(1);
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        foreach (codes[j]) begin
            word <= codes[j];
            idle(20);
            `CHK(csh, codes[j])
            `CHK(tsh, ~codes[j])
        end
        txen <= 1'b0;
        idle(20);
        `CHK(sv, 1'b0)
        apb(1'b1, ADDR_CFG_THREE, 32'h3);
        idle(20);
        `CHK(sv, 1'b1)
        rdc(ADDR_STAT_ZERO, 32'h3);
        rdc(ADDR_IRQ_STAT, 32'h1);
        apb(1'b1, ADDR_CFG_THREE, 32'h1);
        idle(20);
        `CHK(sv, 1'b0)
        `CHK(sample, 16'h0)
        apb(1'b1, ADDR_CFG_THREE, 32'h0);
        apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        run <= 1'b0;
        idle(60);
        rdc(ADDR_STAT_ZERO, 32'h0);
        rdc(ADDR_IRQ_STAT, 32'h4);
        results();
    end
endmodule : test_dac_sync_gate_and_dll_control
